// *** pkg/tbus_pkg.sv ***
// constants for the receive telecom bus parity and alarm block
package tbus_pkg;
	// register indices as printed, byte address is four times the index
	localparam logic [11:0] CTRL_IDX = 12'h137;
	localparam logic [11:0] STAT_IDX = 12'h138;
	localparam logic [11:0] MASK_IDX = 12'h139;
	localparam logic [11:0] DATA_IDX = 12'h13a;
	localparam logic [11:0] AIS_IDX = 12'h13b;
	localparam int ADDR_W = 14;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] AIS_ADDR = {AIS_IDX, 2'b00};
	// control field positions
	localparam int CTL_ODD = 0;
	localparam int CTL_COVER = 1;
	localparam int CTL_ENABLE = 2;
	localparam int CTL_MODE_LO = 3;
	localparam int CTL_AGGR = 5;
	localparam int CTL_APS_EN = 6;
	localparam int CTL_APS_DRV = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// operating modes held in control bits 4:3
	localparam logic [1:0] MODE_TBUS = 2'h0;
	localparam logic [1:0] MODE_ATM_PPP = 2'h1;
	localparam logic [1:0] MODE_HIGH_RATE = 2'h2;
	// status and mask layout
	localparam int ST_PAR = 0;
	localparam int ST_AIS_LO = 1;
	localparam int STS_N = 3;
	localparam logic [3:0] STAT_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// bus and system clock figures
	localparam real BUS_CLK_MHZ = 19.44;
	localparam real SYS_CLK_MHZ = 10.0;
endpackage : tbus_pkg

// *** design/parity_check.sv ***
// parity checker over a byte with optional framing bits
`timescale 1ns/1ps
module parity_check #(
	parameter int DATA_W = 8
) (
	input wire logic [DATA_W-1:0] data,
	input wire logic payload_flag,
	input wire logic phase_marker,
	input wire logic parity_bit,
	input wire logic cover_marks,
	input wire logic odd_sense,
	output logic mismatch
);
	logic sum;

	// even sense wants an even count of ones including the parity bit
	always_comb begin
		sum = ^data ^ parity_bit;
		if (cover_marks) begin
			sum = sum ^ payload_flag ^ phase_marker;
		end
		mismatch = sum ^ odd_sense;
	end
endmodule : parity_check

// *** design/telecom_bus_rx.sv ***
// receive telecom bus sampler with parity check, alarm tracking and register slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module telecom_bus_rx #(
	parameter int DATA_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tbus_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tbus_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_bus_clk_in,
	input wire logic [DATA_W-1:0] rx_bus_data_in,
	input wire logic rx_bus_payload_flag,
	input wire logic rx_bus_phase_marker,
	input wire logic rx_bus_parity_in,
	input wire logic rx_bus_alarm_in,
	output logic [DATA_W-1:0] aps_rx_data_out,
	output logic aps_rx_data_oe,
	output logic aps_rx_parity_out,
	output logic aps_rx_parity_oe,
	output logic [DATA_W-1:0] rx_byte_out,
	output logic rx_byte_valid,
	output logic [DATA_W-1:0] high_rate_rx_data_in,
	output logic high_rate_valid,
	output logic [tbus_pkg::STS_N-1:0] ais_defect,
	output logic irq
);
	import tbus_pkg::*;

	if (DATA_W != 8) begin : g_width_check
		$error("telecom bus data width must be 8");
	end

	// register state
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [3:0] stat_r, stat_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic irq_r, irq_nxt;
	// write channel state
	logic aw_held_r, aw_held_nxt, awready_r, awready_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic w_held_r, w_held_nxt, wready_r, wready_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	// read channel state
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	// receive path state
	logic bclk_d_r, bclk_d_nxt;
	logic [1:0] sts_idx_r, sts_idx_nxt;
	logic [DATA_W-1:0] byte_r, byte_nxt;
	logic byte_valid_r, byte_valid_nxt;
	logic [DATA_W-1:0] hr_r, hr_nxt;
	logic hr_valid_r, hr_valid_nxt;
	logic [STS_N-1:0] ais_r, ais_nxt;
	logic [DATA_W-1:0] aps_data_r, aps_data_nxt;
	logic aps_oe_r, aps_oe_nxt;
	logic aps_par_r, aps_par_nxt;

	logic sample;
	logic par_err;
	logic [1:0] mode;
	logic aps_ok;
	logic bus_mode;
	logic do_write;
	logic [1:0] cur_sts;
	logic [STS_N-1:0] ais_evt;

	// receive bus clock falling edge seen in the system clock
	assign sample = bclk_d_r & ~rx_bus_clk_in;
	assign mode = ctrl_r[CTL_MODE_LO+1:CTL_MODE_LO];
	// aps role needs ATM or PPP mode and no aggregation
	assign aps_ok = ctrl_r[CTL_APS_EN] & (mode == MODE_ATM_PPP) & ~ctrl_r[CTL_AGGR];
	assign bus_mode = ctrl_r[CTL_ENABLE] & (mode == MODE_TBUS) & ~aps_ok;
	assign do_write = aw_held_r & w_held_r & ~bvalid_r;
	// a C1/J0 overhead byte (phase marker without payload flag) restarts the STS-1 rotation at itself as STS-1 0
	assign cur_sts = (rx_bus_phase_marker & ~rx_bus_payload_flag) ? 2'h0 : sts_idx_r;

	parity_check #(
		.DATA_W(DATA_W)
	) u_parity (
		.data(rx_bus_data_in),
		.payload_flag(rx_bus_payload_flag),
		.phase_marker(rx_bus_phase_marker),
		.parity_bit(rx_bus_parity_in),
		.cover_marks(ctrl_r[CTL_COVER]),
		.odd_sense(ctrl_r[CTL_ODD]),
		.mismatch(par_err)
	);

	// per STS-1 alarm events on each sampled byte
	always_comb begin
		for (int i = 0; i < STS_N; i++) begin
			ais_evt[i] = sample & bus_mode & rx_bus_alarm_in & (cur_sts == 2'(i));
		end
	end

	// receive path next state
	always_comb begin
		bclk_d_nxt = rx_bus_clk_in;
		sts_idx_nxt = sts_idx_r;
		byte_nxt = byte_r;
		byte_valid_nxt = 1'b0;
		hr_nxt = hr_r;
		hr_valid_nxt = 1'b0;
		ais_nxt = ais_r;
		aps_data_nxt = aps_data_r;
		aps_par_nxt = aps_par_r;
		if (sample && bus_mode) begin
			byte_nxt = rx_bus_data_in;
			byte_valid_nxt = 1'b1;
			sts_idx_nxt = (cur_sts == 2'h2) ? 2'h0 : cur_sts + 2'h1;
			ais_nxt[cur_sts] = rx_bus_alarm_in;
			aps_data_nxt = rx_bus_data_in;
			aps_par_nxt = ^rx_bus_data_in ^ ctrl_r[CTL_ODD];
		end
		if (sample && ctrl_r[CTL_ENABLE] && mode == MODE_HIGH_RATE) begin
			hr_nxt = rx_bus_data_in;
			hr_valid_nxt = 1'b1;
		end
		if (!ctrl_r[CTL_ENABLE]) begin
			ais_nxt = '0;
		end
		// pins drive only in the permitted aps role
		aps_oe_nxt = aps_ok & ctrl_r[CTL_APS_DRV];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bclk_d_r <= 1'b0;
			sts_idx_r <= 2'h0;
			byte_r <= '0;
			byte_valid_r <= 1'b0;
			hr_r <= '0;
			hr_valid_r <= 1'b0;
			ais_r <= '0;
			aps_data_r <= '0;
			aps_oe_r <= 1'b0;
			aps_par_r <= 1'b0;
		end else begin
			bclk_d_r <= bclk_d_nxt;
			sts_idx_r <= sts_idx_nxt;
			byte_r <= byte_nxt;
			byte_valid_r <= byte_valid_nxt;
			hr_r <= hr_nxt;
			hr_valid_r <= hr_valid_nxt;
			ais_r <= ais_nxt;
			aps_data_r <= aps_data_nxt;
			aps_oe_r <= aps_oe_nxt;
			aps_par_r <= aps_par_nxt;
		end
	end

	// register file next state, event set wins over clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		if (do_write && wstrb_r[0]) begin
			case (awaddr_r)
				CTRL_ADDR: ctrl_nxt = wdata_r[7:0];
				STAT_ADDR: stat_nxt = stat_r & ~wdata_r[3:0];
				MASK_ADDR: mask_nxt = wdata_r[3:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		stat_nxt[ST_PAR] = stat_nxt[ST_PAR] | (sample & bus_mode & par_err);
		stat_nxt[ST_AIS_LO+STS_N-1:ST_AIS_LO] = stat_nxt[ST_AIS_LO+STS_N-1:ST_AIS_LO] | ais_evt;
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET;
			stat_r <= STAT_RESET;
			mask_r <= MASK_RESET;
			irq_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// write channel: address and data in either order, then response
	always_comb begin
		aw_held_nxt = aw_held_r;
		awaddr_nxt = awaddr_r;
		w_held_nxt = w_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && awready_r) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case (awaddr_r)
				CTRL_ADDR, STAT_ADDR, MASK_ADDR: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
		wready_nxt = ~w_held_nxt & ~bvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b0;
			awaddr_r <= '0;
			w_held_r <= 1'b0;
			wready_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			aw_held_r <= aw_held_nxt;
			awready_r <= awready_nxt;
			awaddr_r <= awaddr_nxt;
			w_held_r <= w_held_nxt;
			wready_r <= wready_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// read channel: one read at a time, answer one cycle after address
	always_comb begin
		arready_nxt = arready_r | ~rvalid_r; // idle after reset raises ready
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case (s_axi_araddr)
				CTRL_ADDR: rdata_nxt = {24'h0, ctrl_r};
				STAT_ADDR: rdata_nxt = {28'h0, stat_r};
				MASK_ADDR: rdata_nxt = {28'h0, mask_r};
				DATA_ADDR: rdata_nxt = {24'h0, byte_r};
				AIS_ADDR: rdata_nxt = {29'h0, ais_r};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rx_byte_out = byte_r;
	assign rx_byte_valid = byte_valid_r;
	assign high_rate_rx_data_in = hr_r;
	assign high_rate_valid = hr_valid_r;
	assign ais_defect = ais_r;
	assign aps_rx_data_out = aps_data_r;
	assign aps_rx_data_oe = aps_oe_r;
	assign aps_rx_parity_out = aps_par_r;
	assign aps_rx_parity_oe = aps_oe_r;
	assign irq = irq_r;
endmodule : telecom_bus_rx

// *** test/bus_source.sv ***
// far-end framer model driving the receive telecom bus
`timescale 1ns/1ps
module bus_source (
	input wire logic aclk,
	output logic bclk,
	output logic [7:0] d,
	output logic pl,
	output logic mk,
	output logic par,
	output logic alm
);
	// bus clock stands low between bytes
	initial begin
		bclk = 0;
		d = 8'h00;
		pl = 0;
		mk = 0;
		par = 0;
		alm = 0;
	end
	// one byte per bus clock period, slower than aclk/2 so it can be tracked
	task send(input logic [7:0] v, input logic p, m, a, odd, cov, bad);
		@(posedge aclk);
		bclk <= 1;
		d <= v;
		pl <= p;
		mk <= m;
		alm <= a;
		par <= ^v ^ (cov & (p ^ m)) ^ odd ^ bad;
		repeat (2) @(posedge aclk);
		bclk <= 0;
		repeat (2) @(posedge aclk);
		d <= ~v; // hold over, no stale data
		par <= ~par;
	endtask : send
endmodule : bus_source

// *** test/telecom_bus_rx_assertions.sv ***
// concurrent checks on the receive telecom bus block ports
`timescale 1ns/1ps
module tbus_rx_checker #(
	parameter int DATA_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rx_bus_clk_in,
	input wire logic [DATA_W-1:0] rx_bus_data_in,
	input wire logic [DATA_W-1:0] rx_byte_out,
	input wire logic rx_byte_valid,
	input wire logic [DATA_W-1:0] high_rate_rx_data_in,
	input wire logic high_rate_valid,
	input wire logic aps_rx_data_oe,
	input wire logic aps_rx_parity_oe,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_byte_cause: assert property (rx_byte_valid |->
		$past(rx_bus_clk_in, 2) && !$past(rx_bus_clk_in)) else $error("byte without falling edge");
	chk_byte_data: assert property (rx_byte_valid |->
		rx_byte_out == $past(rx_bus_data_in)) else $error("byte value wrong");
	chk_valid_pulse: assert property (rx_byte_valid |=> !rx_byte_valid)
		else $error("byte valid too long");
	chk_hr_data: assert property (high_rate_valid |->
		high_rate_rx_data_in == $past(rx_bus_data_in)) else $error("high-rate value wrong");
	chk_hr_excl: assert property (high_rate_valid |-> !rx_byte_valid)
		else $error("high-rate and bus byte together");
	chk_aps_excl: assert property (aps_rx_data_oe |-> !rx_byte_valid)
		else $error("bus byte while aps drives");
	chk_aps_pair: assert property (aps_rx_data_oe == aps_rx_parity_oe)
		else $error("aps enables differ");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule : tbus_rx_checker
bind telecom_bus_rx tbus_rx_checker #(.DATA_W(DATA_W)) chk (.aclk(aclk), .aresetn(aresetn),
	.rx_bus_clk_in(rx_bus_clk_in), .rx_bus_data_in(rx_bus_data_in), .rx_byte_out(rx_byte_out),
	.rx_byte_valid(rx_byte_valid), .high_rate_rx_data_in(high_rate_rx_data_in),
	.high_rate_valid(high_rate_valid), .aps_rx_data_oe(aps_rx_data_oe),
	.aps_rx_parity_oe(aps_rx_parity_oe), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata));

// *** test/tb_top.sv ***
// testbench for the receive telecom bus block
`timescale 1ns/1ps
module tb_top;
	import tbus_pkg::*;
	logic aclk, aresetn, awv, awr, wv, wrdy, bv, brd, arv, ardy, rv, rrd;
	logic [13:0] awa, ara;
	logic [31:0] wd, rdt;
	logic [3:0] ws;
	logic [1:0] brs, rrs, r;
	logic bclk, pl, mk, par, alm, bval, hval, doe, poe, pout, irq;
	logic [7:0] bd, bout, hout, dout, last_b, last_h;
	logic [2:0] ais;
	int miscompares, total_checks, cyc, nbytes;
	// 10 MHz system clock
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	telecom_bus_rx dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(brs), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ardy),
		.s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.rx_bus_clk_in(bclk), .rx_bus_data_in(bd), .rx_bus_payload_flag(pl),
		.rx_bus_phase_marker(mk), .rx_bus_parity_in(par), .rx_bus_alarm_in(alm),
		.aps_rx_data_out(dout), .aps_rx_data_oe(doe), .aps_rx_parity_out(pout),
		.aps_rx_parity_oe(poe), .rx_byte_out(bout), .rx_byte_valid(bval),
		.high_rate_rx_data_in(hout), .high_rate_valid(hval), .ais_defect(ais), .irq(irq));
	bus_source src (.aclk(aclk), .bclk(bclk), .d(bd), .pl(pl), .mk(mk), .par(par), .alm(alm));
	// byte monitor and hang guard
	always @(posedge aclk) begin
		cyc++;
		if (bval) begin
			nbytes++;
			last_b = bout;
		end
		if (hval) last_h = hout;
		if (cyc == 5000) begin
			miscompares++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task ck(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask : ck
	task wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic pa, pw;
		pa = 1;
		pw = 1;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		brd <= 1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awr) begin
				pa = 0;
				awv <= 0;
			end
			if (pw && wrdy) begin
				pw = 0;
				wv <= 0;
			end
		end
		do @(posedge aclk); while (!bv);
		rs = brs;
		brd <= 0;
		@(posedge aclk);
	endtask : wr
	task rc(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] rs;
		ara <= a;
		arv <= 1;
		rrd <= 1;
		do @(posedge aclk); while (!ardy);
		arv <= 0;
		do @(posedge aclk); while (!rv);
		d = rdt;
		rs = rrs;
		rrd <= 0;
		@(posedge aclk);
		ck(d, e);
		ck(32'(rs), 32'(er));
	endtask : rc
	task t_regs;
		rc(CTRL_ADDR, 32'h0, RESP_OKAY);
		rc(STAT_ADDR, 32'h0, RESP_OKAY);
		rc(MASK_ADDR, 32'h0, RESP_OKAY);
		rc(14'h0010, 32'h0, RESP_SLVERR);
		wr(DATA_ADDR, 32'h1, r);
		ck(32'(r), 32'(RESP_SLVERR));
		wr(CTRL_ADDR, 32'hffffff5b, r);
		rc(CTRL_ADDR, 32'h5b, RESP_OKAY);
		$display("regs done");
	endtask : t_regs
	task t_parity;
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_ADDR, 32'h4 | i, r);
			wr(MASK_ADDR, 32'(i != 0), r);
			wr(STAT_ADDR, 32'hf, r);
			src.send(8'h96, 1, 0, 0, i[0], i[1], 0);
			rc(STAT_ADDR, 32'h0, RESP_OKAY);
			ck(32'(last_b), 32'h96);
			src.send(8'h96, 1, 0, 0, i[0], i[1], 1);
			rc(STAT_ADDR, 32'h1, RESP_OKAY);
			ck(32'(irq), 32'(i != 0));
			wr(STAT_ADDR, 32'h1, r);
			rc(STAT_ADDR, 32'h0, RESP_OKAY);
		end
		$display("parity done");
	endtask : t_parity
	task t_alarm;
		wr(CTRL_ADDR, 32'h4, r);
		wr(STAT_ADDR, 32'hf, r);
		src.send(8'h5a, 0, 1, 0, 0, 0, 0);
		src.send(8'h3c, 0, 0, 1, 0, 0, 0);
		src.send(8'hc3, 0, 0, 0, 0, 0, 0);
		ck(32'(ais), 32'h2);
		rc(STAT_ADDR, 32'h4, RESP_OKAY);
		$display("alarm done");
	endtask : t_alarm
	task t_modes;
		int n;
		wr(CTRL_ADDR, 32'h14, r);
		n = nbytes;
		src.send(8'ha5, 1, 0, 0, 0, 0, 0);
		@(posedge aclk);
		ck(32'(last_h), 32'ha5);
		ck(32'(nbytes), 32'(n));
		for (int i = 0; i < 3; i++) begin
			wr(CTRL_ADDR, (i == 0) ? 32'hc8 : ((i == 1) ? 32'he8 : 32'hc0), r);
			repeat (2) @(posedge aclk);
			ck(32'({doe, poe}), (i == 0) ? 32'h3 : 32'h0);
			if (i == 0) ck(32'({dout, pout}), {23'h0, 8'hc3, 1'b0});
		end
		$display("modes done");
	endtask : t_modes
	// reset, then the scenarios in turn
	initial begin
		aresetn = 0;
		awv = 0;
		wv = 0;
		brd = 0;
		arv = 0;
		rrd = 0;
		awa = 14'h0000;
		ara = 14'h0000;
		wd = 32'h0;
		ws = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs;
		t_parity;
		t_alarm;
		t_modes;
		give_verdict;
	end
endmodule : tb_top
